// [test/adcsp_host.sv]
`default_nettype none
module adcsp_host (
  // pins
  input  wire logic clock,
  input  wire logic sdo,
  output var logic  cs_n,
  output var logic  sck,
  output var logic  sdi
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    cs_n = 1'b1;
    sck  = 1'b0;
    sdi  = 1'b1;
  end
  // half of the 160 ns link period, moved off the sampling edge
  task automatic half();
    repeat (16) @(posedge clock);
    #1;
  endtask
  // nf pulses; cs rises after the last fall, so nf < 24 is an abort
  task automatic frame(input logic [7:0] din, input int nf, output logic [24:0] dout);
    dout = '0;
    half();
    cs_n = 1'b0;
    for (int i = 0; i < 400 && sdo !== 1'b0; i++) half();
    for (int i = 0; i < nf; i++) begin
      // past the word the line toggles so no stale value looks valid
      sdi = (i < 8) ? din[7 - i] : ~sdi;
      half();
      sck = 1'b1;
      dout = {dout[23:0], sdo};
      half();
      sck = 1'b0;
    end
    half();
    dout = {dout[23:0], sdo};
    cs_n = 1'b1;
    half();
  endtask
  task automatic pick_mode(input logic lvl);
    sck = lvl;
    half();
    cs_n = 1'b0;
    half();
    cs_n = 1'b1;
    half();
    sck = 1'b0;
    half();
  endtask
endmodule // adcsp_host
`default_nettype wire

// [test/adcsp_port_bench.sv]
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module adcsp_port_bench
  import adcsp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock, rst, cs_n, sck, sdi, sdo_o, sdo_oe, conv_done, internal_sck_mode, low_power;
  logic [22:0] conv_result = 23'h2a5a5a;
  adcsp_conv_s conv;
  wire logic sdo = sdo_oe ? sdo_o : 1'bz;
  int fail_count = 0;
  int n_checks = 0;
  int nstart = 0;
  logic [24:0] d;
  logic [7:0] cnt;
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  adcsp_port i_adcsp_port (.clock(clock), .rst(rst), .cs_n(cs_n), .sck(sck), .sdi(sdi),
    .sdo_o(sdo_o), .sdo_oe(sdo_oe), .conv_done(conv_done), .conv_result(conv_result),
    .conv_o(conv), .internal_sck_mode(internal_sck_mode), .low_power(low_power));
  adcsp_host i_adcsp_host (.clock(clock), .sdo(sdo), .cs_n(cs_n), .sck(sck), .sdi(sdi));
  // converter core stand-in: 41 clocks of conversion after each start
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      conv_done <= 1'b0;
      cnt <= 8'h00;
    end else if (conv.start) begin
      conv_done <= 1'b0;
      cnt <= 8'h00;
    end else if (!conv_done) begin
      cnt <= cnt + 8'h01;
      conv_done <= (cnt == 8'h28);
    end
  end
  always @(posedge clock) if (conv.start === 1'b1) nstart++;
  task automatic summarize();
    if (fail_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic t_idle();
    `CHK("sel", SEL_RESET, conv.sel)
    repeat (60) @(posedge clock);
    `CHK("low_power", 1'b1, low_power)
    `CHK("sdo_oe", 1'b0, sdo_oe)
  endtask
  task automatic t_frame(input logic [7:0] w, input int nf, input logic [4:0] sel);
    int s;
    s = nstart;
    i_adcsp_host.frame(w, nf, d);
    if (nf == 24) `CHK("frame", {1'b0, conv_result, 1'b1}, d)
    `CHK("start", s + 1, nstart)
    `CHK("sel", sel, conv.sel)
  endtask
  task automatic t_mode(input logic lvl);
    i_adcsp_host.pick_mode(lvl);
    `CHK("mode", lvl, internal_sck_mode)
  endtask
  initial begin
    rst = 1'b1;
    repeat (10) @(posedge clock);
    #1 rst = 1'b0;
    t_idle();
    t_frame(8'ha3, 24, 5'h03);
    t_frame(8'hbd, 24, 5'h1d);
    t_frame(8'hb1, 5, 5'h1d);
    t_frame(8'hb1, 9, 5'h11);
    t_frame(8'h9f, 24, 5'h11);
    t_frame(8'h1f, 24, 5'h11);
    t_mode(1'b1);
    t_mode(1'b0);
    summarize();
  end
  initial begin
    #200000;
    fail_count++;
    summarize();
  end
endmodule // adcsp_port_bench
`default_nettype wire

// [verilog/adcsp_pkg.sv]
`default_nettype none
package adcsp_pkg;
  // -----------------------------------------------------------------
  // widths and counts
  // -----------------------------------------------------------------
  localparam int unsigned RESULT_BITS   = 24;
  localparam int unsigned SEL_BITS      = 8;
  localparam logic [4:0]  LAST_FALL     = 5'h18;
  localparam logic [4:0]  SEL_FALL      = 5'h08;
  localparam logic [2:0]  PREFIX_LOAD   = 3'h5;
  localparam logic [4:0]  SEL_RESET     = 5'h00;
  localparam logic [22:0] RESULT_RESET  = 23'h000000;
  localparam logic [7:0]  SEL_RX_RESET  = 8'h00;

  // decoded channel selection
  typedef struct packed {
    logic       single_ended_select;
    logic       pair_swap;
    logic [2:0] channel_index;
  } adcsp_sel_s;

  // analog side handshake towards the converter core
  typedef struct packed {
    logic        start;
    adcsp_sel_s  sel;
  } adcsp_conv_s;

  typedef enum logic [1:0] {
    ADCSP_CONVERT,
    ADCSP_SLEEP,
    ADCSP_XFER
  } adcsp_state_e;
endpackage
`default_nettype wire

// [verilog/adcsp_port.sv]
// Summary of operation
// - four timing modes, one common cycle; internal-sck modes only flagged, no engine
// - word formats identical in every mode
// - sck high at cs fall: internal mode
// - sdo high impedance while cs high
// - idle cs low: sdo shows busy flag
// - conversion done enters sleep regardless
// - sleep holds result; first sck rise wakes
// - sdi captured on first eight sck rises
// - new channel applies to next conversion
// - sdo updated on each sck fall
// - 24th sck fall starts new conversion
// - cs may stay low; flag is interrupt
// - cs rise mid transfer aborts, converts
// - abort before 8th fall keeps channel
// - cs rise after 8th fall loads channel
// - prefix 101 loads next five bits
// - single-ended bit: pair or versus common
// - swap plus index pick the channel
// - reset selects pair 0/1, starts conversion
`default_nettype none
module adcsp_port
  import adcsp_pkg::*;
(
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // serial pins (asynchronous to clock)
  input  wire logic        cs_n,
  input  wire logic        sck,
  input  wire logic        sdi,
  output logic             sdo_o,
  output logic             sdo_oe,
  // converter core
  input  wire logic        conv_done,
  input  wire logic [22:0] conv_result,
  output adcsp_conv_s      conv_o,
  output logic             internal_sck_mode,
  output logic             low_power
);

  // -----------------------------------------------------------------
  // pin synchronisers
  // -----------------------------------------------------------------
  logic [1:0] cs_s, sck_s, sdi_s;
  logic       cs_d1_q, sck_d1_q;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cs_s     <= 2'h3;
      sck_s    <= 2'h0;
      sdi_s    <= 2'h0;
      cs_d1_q  <= 1'b1;
      sck_d1_q <= 1'b0;
    end else begin
      cs_s     <= {cs_s[0], cs_n};
      sck_s    <= {sck_s[0], sck};
      sdi_s    <= {sdi_s[0], sdi};
      cs_d1_q  <= cs_s[1];
      sck_d1_q <= sck_s[1];
    end
  end

  logic cs_fall, cs_rise, sck_rise, sck_fall, cs_low;
  assign cs_low   = ~cs_s[1];
  assign cs_fall  = cs_d1_q & ~cs_s[1];
  assign cs_rise  = ~cs_d1_q & cs_s[1];
  assign sck_rise = cs_low & ~sck_d1_q & sck_s[1];
  assign sck_fall = cs_low & sck_d1_q & ~sck_s[1];

  // -----------------------------------------------------------------
  // mode flag
  // -----------------------------------------------------------------
  // internal-sck engine is not built here; the flag only reports it
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      internal_sck_mode <= 1'b0;
    end else if (cs_fall) begin
      internal_sck_mode <= sck_s[1];
    end
  end

  // -----------------------------------------------------------------
  // cycle state
  // -----------------------------------------------------------------
  adcsp_state_e state_q;
  logic [4:0]   fall_cnt_q;
  logic [22:0]  shift_q;
  logic [7:0]   sel_rx_q;
  logic [3:0]   rise_cnt_q;
  adcsp_sel_s   sel_q;
  logic         start_d;
  logic         conv_fin;
  logic         sel_load;
  adcsp_sel_s   sel_d;

  // one start pulse per new conversion: 24th fall or abort
  assign start_d = (state_q == ADCSP_XFER) &&
                   ((sck_fall && fall_cnt_q == LAST_FALL - 5'h01) || cs_rise);

  // the core lowers conv_done only after it has seen the start pulse, so a
  // done level during that pulse still belongs to the previous conversion
  assign conv_fin = (state_q == ADCSP_CONVERT) && conv_done && !conv_o.start;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_q    <= ADCSP_CONVERT;
      fall_cnt_q <= 5'h00;
    end else begin
      unique case (state_q)
        ADCSP_CONVERT: if (conv_fin) state_q <= ADCSP_SLEEP;
        ADCSP_SLEEP: begin
          fall_cnt_q <= 5'h00;
          if (sck_rise) state_q <= ADCSP_XFER;
        end
        ADCSP_XFER: begin
          if (start_d) state_q <= ADCSP_CONVERT;
          if (sck_fall) fall_cnt_q <= fall_cnt_q + 5'h01;
        end
      endcase
    end
  end

  // result held in sleep, shifted on falls
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      shift_q <= RESULT_RESET;
    end else if (conv_fin) begin
      shift_q <= conv_result;
    end else if (state_q == ADCSP_XFER && sck_fall) begin
      shift_q <= {shift_q[21:0], 1'b0};
    end
  end

  // input word, one bit per rise, first rise included
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sel_rx_q   <= SEL_RX_RESET;
      rise_cnt_q <= 4'h0;
    end else if (state_q == ADCSP_SLEEP) begin
      rise_cnt_q <= 4'h0;
      if (sck_rise) begin
        sel_rx_q   <= {sel_rx_q[6:0], sdi_s[1]};
        rise_cnt_q <= 4'h1;
      end
    end else if (state_q == ADCSP_XFER && sck_rise && rise_cnt_q < 4'(SEL_BITS)) begin
      sel_rx_q   <= {sel_rx_q[6:0], sdi_s[1]};
      rise_cnt_q <= rise_cnt_q + 4'h1;
    end
  end

  // -----------------------------------------------------------------
  // channel selection
  // -----------------------------------------------------------------
  // a word counts only once eight falls are in, whether the frame ends or is cut
  assign sel_load = start_d
                    && (fall_cnt_q + (sck_fall ? 5'h01 : 5'h00)) >= SEL_FALL
                    && sel_rx_q[7:5] == PREFIX_LOAD;
  assign sel_d    = sel_load ? adcsp_sel_s'(sel_rx_q[4:0]) : sel_q;

  // the new word must ride on the very start that ends its frame, so the
  // core sees sel_d rather than the register
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sel_q <= adcsp_sel_s'(SEL_RESET);
    end else begin
      sel_q <= sel_d;
    end
  end

  // -----------------------------------------------------------------
  // outputs
  // -----------------------------------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      conv_o    <= '{start: 1'b1, sel: adcsp_sel_s'(SEL_RESET)};
      sdo_o     <= 1'b1;
      sdo_oe    <= 1'b0;
      low_power <= 1'b0;
    end else begin
      conv_o.start <= start_d;
      if (start_d) conv_o.sel <= sel_d;
      sdo_oe    <= cs_low;
      low_power <= (state_q == ADCSP_SLEEP) && !cs_low;
      unique case (state_q)
        ADCSP_CONVERT: sdo_o <= ~conv_fin;
        ADCSP_SLEEP:   sdo_o <= 1'b0;
        ADCSP_XFER: begin
          // the flag stays low until the first fall; the host reads it on rise one
          if (start_d) begin
            sdo_o <= 1'b1;
          end else if (sck_fall) begin
            sdo_o <= shift_q[22];
          end
        end
      endcase
    end
  end

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  a_sdo_hiz_high: assert property (
    @(posedge clock) disable iff (rst) cs_s[1] |=> !sdo_oe)
    else $error("sdo driven while cs high");
  a_flag_in_sleep: assert property (
    @(posedge clock) disable iff (rst) (state_q == ADCSP_SLEEP) |=> !sdo_o)
    else $error("flag not low in sleep");
  a_mode_flag_hold: assert property (
    @(posedge clock) disable iff (rst) !cs_fall |=> $stable(internal_sck_mode))
    else $error("mode flag moved");
  a_mode_on_fall: assert property (
    @(posedge clock) disable iff (rst) cs_fall |=> internal_sck_mode == $past(sck_s[1]))
    else $error("mode not sampled");
  a_last_fall_start: assert property (
    @(posedge clock) disable iff (rst) (state_q == ADCSP_XFER && sck_fall && fall_cnt_q == 5'h17)
    |=> conv_o.start && sdo_o) else $error("no start at 24th fall");
  a_abort_start: assert property (
    @(posedge clock) disable iff (rst)
    (state_q == ADCSP_XFER && cs_rise) |=> conv_o.start && state_q == ADCSP_CONVERT)
    else $error("abort did not restart");
  a_short_keeps_sel: assert property (
    @(posedge clock) disable iff (rst) (start_d && fall_cnt_q < 5'h07) |=> $stable(sel_q))
    else $error("short abort loaded");
  a_sel_only_start: assert property (
    @(posedge clock) disable iff (rst) !start_d |=> $stable(conv_o.sel))
    else $error("select changed mid cycle");
  a_wake_on_rise: assert property (
    @(posedge clock) disable iff (rst)
    (state_q == ADCSP_SLEEP && !sck_rise) |=> state_q == ADCSP_SLEEP)
    else $error("left sleep without sck");
  a_sdo_on_fall: assert property (
    @(posedge clock) disable iff (rst)
    (state_q == ADCSP_XFER && !sck_fall && !start_d) |=> $stable(sdo_o))
    else $error("sdo moved off an sck fall");

endmodule // adcsp_port
`default_nettype wire
